//--- core/bnms_pkg.sv
/*
  constants, modes and carriers for the bus node mode and supervisor block.
  assumes a 100 MHz hclk; all times below are converted to cycles here.
*/
package bnms_pkg;
  // ************************************************
  // timing
  // ************************************************
  localparam int CLK_MHZ      = 100;
  localparam int FREQ_WIN_US  = 200;
  localparam int FREQ_WIN_CYC = FREQ_WIN_US * CLK_MHZ;
  localparam int WDOG_US      = 20;
  localparam int WDOG_CYC     = WDOG_US * CLK_MHZ;
  localparam int HOT_S        = 2;
  localparam int HOT_CYC      = HOT_S * 1000000 * CLK_MHZ;
  localparam int BIT_NS       = 6000;
  localparam int BIT_CYC      = BIT_NS * CLK_MHZ / 1000;
  localparam int HALF_CYC     = BIT_CYC / 2;
  localparam int TOL_CYC      = BIT_CYC / 8;
  localparam logic [11:0] HALF_LO = 12'(HALF_CYC - TOL_CYC);
  localparam logic [11:0] HALF_HI = 12'(HALF_CYC + TOL_CYC);
  localparam logic [11:0] FULL_LO = 12'(BIT_CYC - TOL_CYC);
  localparam logic [11:0] FULL_HI = 12'(BIT_CYC + TOL_CYC);
  localparam logic [11:0] END_GAP = 12'(2 * BIT_CYC);
  localparam logic [11:0] WDOG_LIM = 12'(WDOG_CYC);
  localparam logic [8:0]  TX_HALF = 9'(HALF_CYC - 1);
  localparam logic [1:0]  INIT_WAIT = 2'h3;
  // ************************************************
  // telegram and register map
  // ************************************************
  localparam logic [3:0]  MC_BITS    = 4'he;
  localparam logic [3:0]  SR_BITS    = 4'h7;
  localparam logic [3:0]  TX_HALVES  = 4'he;
  localparam logic [7:0]  REG_STATUS = 8'h00;
  localparam logic [7:0]  REG_CTRL   = 8'h04;
  localparam logic [7:0]  REG_RXDATA = 8'h08;
  localparam logic [7:0]  REG_LEVEL  = 8'h0c;
  localparam logic [31:0] CTRL_RST   = 32'h0000_0001;
  localparam int          CTRL_STORE = 0;
  localparam int          FIFO_DEPTH = 32;

  typedef enum logic [1:0] {
    BNMS_SLAVE    = 2'b00,
    BNMS_MONITOR  = 2'b01,
    BNMS_MASTER   = 2'b10,
    BNMS_REPEATER = 2'b11
  } bnms_mode_e;

  typedef enum logic {
    BNMS_DEC_IDLE = 1'b0,
    BNMS_DEC_RUN  = 1'b1
  } bnms_dec_e;

  typedef struct packed {
    logic       master_call;
    logic [3:0] nbits;
    logic [13:0] bits;
  } bnms_frame_s;

  localparam int FRAME_W = $bits(bnms_frame_s);

  typedef struct packed {
    logic       p_pulse;
    logic       n_pulse;
    logic [2:0] adc;
    logic       osc;
    logic       hot;
    logic       rail_short;
    logic       xtal_8m;
    logic       addr_ch;
    logic       nv_master;
    logic       nv_relay;
  } bnms_pins_s;
endpackage : bnms_pkg

//--- core/bnms_top.sv
/*
  mode decode, crystal detect and lock, clock watchdog, thermal shutdown,
  telegram receive with strobes, response encoder, ahb-lite register slave.
  assumes a single ahb-lite master with bnms as the only slave; all pins except
  the ahb and response ports are asynchronous and pass two flip-flops first.
*/
// Our own choices: the address map and the AHB-Lite register port.
`timescale 1ns/1ns
// ************************************************
// frame fifo
// ************************************************
module bnms_fifo #(
  parameter int WIDTH = 19,
  parameter int DEPTH = 32
) (
  input  wire logic                       clk,
  input  wire logic                       rst_n,
  input  wire logic                       in_valid,
  output logic                            in_ready,
  input  wire logic [WIDTH-1:0]           in_data,
  output logic                            out_valid,
  input  wire logic                       out_ready,
  output logic [WIDTH-1:0]                out_data,
  output logic [$clog2(DEPTH):0]          count
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wp_ff;
  logic [AW-1:0]    rp_ff;
  logic [AW:0]      cnt_ff;
  wire              push = in_valid & in_ready;
  wire              pop  = out_valid & out_ready;

  assign in_ready  = (cnt_ff != (AW+1)'(DEPTH));
  assign out_valid = (cnt_ff != '0);
  assign out_data  = mem[rp_ff];
  assign count     = cnt_ff;

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wp_ff] <= in_data;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wp_ff  <= '0;
      rp_ff  <= '0;
      cnt_ff <= '0;
    end else begin
      wp_ff  <= push ? wp_ff + 1'b1 : wp_ff;
      rp_ff  <= pop ? rp_ff + 1'b1 : rp_ff;
      cnt_ff <= cnt_ff + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    end
  end
endmodule : bnms_fifo

// What this block does
// - mode from master and relay flags: 00 slave, 10 master, 11 repeater, 01 monitor
// - flags captured at each initialization, mode frozen while running
// - start at 16 MHz, after 200 us keep or change per detected crystal
// - detection runs until first good telegram, then setting is frozen
// - slave locks on master call; other modes on any good telegram
// - no oscillation for over 20 us forces device reset
// - over-temperature beyond 2 s disables inductor, resets, powers down analog
// - shutdown is latched until bus power is removed and reapplied
// - inductor rail short to ground acts exactly like overheating
// - first pulse amplitude code sets comparator thresholds near half
// - slave mode decodes and checks telegrams, strobes main machine after good master call
// - response data is sent as a manchester-ii stream to the transmitter
// - memory writes and main machine i/o only in slave mode
// - master mode gives one strobe per good slave response
// - monitor mode strobes master and slave telegrams separately
// - power-fail pin is digital in slave mode, analog in master mode
// - addressing input is aux receiver in slave, transmitter input in master
module bnms_top #(
  parameter int FREQ_WIN = bnms_pkg::FREQ_WIN_CYC,
  parameter int HOT_LIM  = bnms_pkg::HOT_CYC
) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic [31:0]      hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        p_pulse,
  input  wire logic        n_pulse,
  input  wire logic [2:0]  adc_code,
  input  wire logic        osc_activity,
  input  wire logic        over_temp,
  input  wire logic        inductor_output_rail_short,
  input  wire logic        xtal_8m,
  input  wire logic        addressing_channel_input,
  input  wire logic        nv_master_flag,
  input  wire logic        nv_relay_flag,
  input  wire logic        resp_valid,
  input  wire logic [3:0]  resp_data,
  output logic             resp_ready,
  output logic             rx_strobe_main,
  output logic             rx_strobe_aux,
  output logic [2:0]       thresh_code,
  output logic             tx_line,
  output logic             tx_enable,
  output logic             rx_line,
  output logic             freq_16m,
  output logic             inductor_en,
  output logic             analog_pd,
  output logic             reset_out,
  output logic             power_fail_sense_pin_analog,
  output logic             addr_rx_enable,
  output logic             nvm_write_allow
);
  // ************************************************
  // pin synchronisers
  // ************************************************
  bnms_pkg::bnms_pins_s raw, s1_ff, s2_ff;
  logic                 p_d_ff, n_d_ff, osc_d_ff;
  assign raw = '{p_pulse: p_pulse, n_pulse: n_pulse, adc: adc_code, osc: osc_activity, hot: over_temp,
                 rail_short: inductor_output_rail_short, xtal_8m: xtal_8m, addr_ch: addressing_channel_input,
                 nv_master: nv_master_flag, nv_relay: nv_relay_flag};
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s1_ff    <= '0;
      s2_ff    <= '0;
      p_d_ff   <= 1'b0;
      n_d_ff   <= 1'b0;
      osc_d_ff <= 1'b0;
    end else begin
      s1_ff    <= raw;
      s2_ff    <= s1_ff;
      p_d_ff   <= s2_ff.p_pulse;
      n_d_ff   <= s2_ff.n_pulse;
      osc_d_ff <= s2_ff.osc;
    end
  end
  wire p_rise = s2_ff.p_pulse & ~p_d_ff;
  wire n_rise = s2_ff.n_pulse & ~n_d_ff;
  wire pulse  = p_rise | n_rise;

  // ************************************************
  // supervisor: watchdog, thermal, init and mode
  // ************************************************
  logic [11:0] wd_cnt_ff;
  logic [27:0] hot_cnt_ff;
  logic        wdog_rst_ff, shutdown_ff;
  logic [1:0]  init_cnt_ff;
  bnms_pkg::bnms_mode_e mode_ff;
  wire srst    = wdog_rst_ff | shutdown_ff;
  wire hot_any = s2_ff.hot | s2_ff.rail_short;
  wire is_slave  = (mode_ff == bnms_pkg::BNMS_SLAVE);
  wire is_master = (mode_ff == bnms_pkg::BNMS_MASTER);
  wire is_rep    = (mode_ff == bnms_pkg::BNMS_REPEATER);
  wire is_mon    = (mode_ff == bnms_pkg::BNMS_MONITOR);
  wire wd_trip   = (wd_cnt_ff >= bnms_pkg::WDOG_LIM);
  wire hot_trip  = hot_any & (hot_cnt_ff >= 28'(HOT_LIM - 1));
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wd_cnt_ff   <= '0;
      wdog_rst_ff <= 1'b0;
      hot_cnt_ff  <= '0;
      shutdown_ff <= 1'b0;
      init_cnt_ff <= bnms_pkg::INIT_WAIT;
      mode_ff     <= bnms_pkg::BNMS_SLAVE;
    end else begin
      wd_cnt_ff   <= (s2_ff.osc != osc_d_ff) ? '0 : (wd_trip ? wd_cnt_ff : wd_cnt_ff + 1'b1);
      wdog_rst_ff <= wd_trip;
      hot_cnt_ff  <= hot_any ? (hot_trip ? hot_cnt_ff : hot_cnt_ff + 1'b1) : '0;
      shutdown_ff <= shutdown_ff | hot_trip;
      init_cnt_ff <= srst ? bnms_pkg::INIT_WAIT : (init_cnt_ff != 2'h0 ? init_cnt_ff - 2'h1 : init_cnt_ff);
      if (init_cnt_ff == 2'h1) begin
        mode_ff <= bnms_pkg::bnms_mode_e'({s2_ff.nv_master, s2_ff.nv_relay});
      end
    end
  end
  wire running = (init_cnt_ff == 2'h0) & ~srst;

  // ************************************************
  // telegram decoder
  // ************************************************
  bnms_pkg::bnms_dec_e dec_ff;
  logic [11:0] gap_ff;
  logic [13:0] sh_ff;
  logic [3:0]  cnt_ff;
  logic        mid_ff, err_ff, pend_ff, locked_ff, store_ff;
  bnms_pkg::bnms_frame_s frame_ff, fifo_out;
  logic        fifo_ready, fifo_valid, fifo_pop;
  logic [5:0]  fifo_cnt;
  wire is_half = (gap_ff >= bnms_pkg::HALF_LO) & (gap_ff <= bnms_pkg::HALF_HI);
  wire is_full = (gap_ff >= bnms_pkg::FULL_LO) & (gap_ff <= bnms_pkg::FULL_HI);
  wire start   = running & (dec_ff == bnms_pkg::BNMS_DEC_IDLE) & pulse & ~pend_ff;
  wire in_run  = running & (dec_ff == bnms_pkg::BNMS_DEC_RUN);
  wire mid_hit = (mid_ff & is_full) | (~mid_ff & is_half);
  wire frm_end = in_run & (gap_ff > bnms_pkg::END_GAP);
  // syntax: start 0, end 1, even parity, exact length
  wire mc_ok = frm_end & ~err_ff & (cnt_ff == bnms_pkg::MC_BITS) & ~sh_ff[13] & sh_ff[0] & ~(^sh_ff[12:1]);
  wire sr_ok = frm_end & ~err_ff & (cnt_ff == bnms_pkg::SR_BITS) & ~sh_ff[6] & sh_ff[0] & ~(^sh_ff[5:1]);
  wire lock_evt = is_slave ? mc_ok : (mc_ok | sr_ok);
  wire keep     = (is_slave ? mc_ok : (mc_ok | sr_ok)) & store_ff;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dec_ff   <= bnms_pkg::BNMS_DEC_IDLE;
      gap_ff   <= '0;
      sh_ff    <= '0;
      cnt_ff   <= '0;
      mid_ff   <= 1'b0;
      err_ff   <= 1'b0;
      pend_ff  <= 1'b0;
      frame_ff <= '0;
      rx_line  <= 1'b0;
      thresh_code <= '0;
    end else begin
      gap_ff  <= pulse ? '0 : (gap_ff == 12'hfff ? gap_ff : gap_ff + 12'h1);
      rx_line <= p_rise ? 1'b1 : (n_rise ? 1'b0 : rx_line);
      pend_ff <= keep | (pend_ff & ~fifo_ready);
      if (keep) begin
        frame_ff <= '{master_call: mc_ok, nbits: cnt_ff, bits: sh_ff};
      end
      if (!running | frm_end) begin
        dec_ff <= bnms_pkg::BNMS_DEC_IDLE;
      end else if (start) begin
        dec_ff <= bnms_pkg::BNMS_DEC_RUN;
        sh_ff  <= {13'h0, n_rise};
        cnt_ff <= 4'h1;
        mid_ff <= 1'b1;
        err_ff <= 1'b0;
        // threshold near half of first pulse
        thresh_code <= 3'(({1'b0, s2_ff.adc} + 4'h1) >> 1);
      end else if (in_run & pulse) begin
        if (mid_hit) begin
          sh_ff  <= {sh_ff[12:0], n_rise};
          cnt_ff <= (cnt_ff == 4'hf) ? cnt_ff : cnt_ff + 4'h1;
          err_ff <= err_ff | (cnt_ff >= bnms_pkg::MC_BITS);
          mid_ff <= 1'b1;
        end else begin
          mid_ff <= 1'b0;
          err_ff <= err_ff | ~(mid_ff & is_half);
        end
      end
    end
  end

  // ************************************************
  // strobes and crystal lock
  // ************************************************
  logic [15:0] win_cnt_ff;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rx_strobe_main <= 1'b0;
      rx_strobe_aux  <= 1'b0;
      locked_ff      <= 1'b0;
      freq_16m       <= 1'b1;
      win_cnt_ff     <= '0;
    end else begin
      rx_strobe_main <= is_master ? sr_ok : mc_ok;
      rx_strobe_aux  <= (is_mon | is_rep) & sr_ok;
      locked_ff      <= locked_ff | lock_evt;
      win_cnt_ff     <= (win_cnt_ff == 16'(FREQ_WIN - 1)) ? '0 : win_cnt_ff + 16'h1;
      // decide at each window end until lock
      if (!locked_ff && !lock_evt && win_cnt_ff == 16'(FREQ_WIN - 1)) begin
        freq_16m <= ~s2_ff.xtal_8m;
      end
    end
  end

  // ************************************************
  // response encoder and pin roles
  // ************************************************
  logic [13:0] tx_sh_ff;
  logic [3:0]  tx_halves_ff;
  logic [8:0]  tx_tmr_ff;
  logic [13:0] tx_load;
  wire  [6:0]  tx_bits = {1'b0, resp_data, ^resp_data, 1'b1};
  wire         tx_busy  = (tx_halves_ff != 4'h0);
  wire         tx_start = resp_valid & resp_ready;
  generate
    for (genvar i = 0; i < 7; i++) begin : g_half
      assign tx_load[2*i+1:2*i] = {~tx_bits[i], tx_bits[i]};
    end
  endgenerate
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tx_sh_ff     <= '0;
      tx_halves_ff <= '0;
      tx_tmr_ff    <= '0;
      tx_line      <= 1'b0;
      tx_enable    <= 1'b0;
      resp_ready   <= 1'b0;
      inductor_en  <= 1'b0;
      analog_pd    <= 1'b1;
      reset_out    <= 1'b1;
      power_fail_sense_pin_analog <= 1'b0;
      addr_rx_enable  <= 1'b0;
      nvm_write_allow <= 1'b0;
    end else begin
      if (tx_start) begin
        tx_sh_ff     <= tx_load;
        tx_halves_ff <= bnms_pkg::TX_HALVES;
        tx_tmr_ff    <= bnms_pkg::TX_HALF;
      end else if (tx_busy) begin
        tx_tmr_ff <= (tx_tmr_ff == 9'h0) ? bnms_pkg::TX_HALF : tx_tmr_ff - 9'h1;
        if (tx_tmr_ff == 9'h0) begin
          tx_sh_ff     <= {tx_sh_ff[12:0], 1'b0};
          tx_halves_ff <= tx_halves_ff - 4'h1;
        end
      end
      // direct transmitter input in master roles
      tx_line   <= (is_master | is_rep) ? s2_ff.addr_ch : (tx_busy & tx_sh_ff[13]);
      tx_enable <= ((is_master | is_rep) | tx_busy) & running;
      // main machine i/o only in slave mode
      resp_ready      <= is_slave & running & ~tx_busy & ~tx_start;
      nvm_write_allow <= is_slave & running;
      addr_rx_enable  <= is_slave & running;
      power_fail_sense_pin_analog <= is_master | is_rep;
      inductor_en <= ~shutdown_ff;
      analog_pd   <= shutdown_ff;
      reset_out   <= srst;
    end
  end

  // ************************************************
  // ahb-lite slave, zero wait states
  // ************************************************
  logic [31:0] ctrl_ff;
  logic        wr_ff;
  logic [7:0]  waddr_ff;
  wire         acc   = hsel & htrans[1] & hready;
  wire  [7:0]  a8    = haddr[7:0];
  wire         rd_rx = acc & ~hwrite & (a8 == bnms_pkg::REG_RXDATA);
  wire  [31:0] stat  = {24'h0, fifo_valid, shutdown_ff, wdog_rst_ff, locked_ff, freq_16m, 1'b0, mode_ff};
  wire  [31:0] level = {21'h0, thresh_code, 2'h0, fifo_cnt};
  wire  [31:0] rmux  = (a8 == bnms_pkg::REG_STATUS) ? stat :
                       (a8 == bnms_pkg::REG_CTRL)   ? ctrl_ff :
                       (a8 == bnms_pkg::REG_RXDATA) ? {13'h0, fifo_out} :
                       (a8 == bnms_pkg::REG_LEVEL)  ? level : 32'h0;
  assign fifo_pop = rd_rx & fifo_valid;
  assign store_ff = ctrl_ff[bnms_pkg::CTRL_STORE];
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_ff   <= bnms_pkg::CTRL_RST;
      wr_ff     <= 1'b0;
      waddr_ff  <= '0;
      hrdata    <= '0;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      wr_ff    <= acc & hwrite;
      waddr_ff <= a8;
      hrdata   <= (acc & ~hwrite) ? rmux : 32'h0;
      if (wr_ff && waddr_ff == bnms_pkg::REG_CTRL) begin
        ctrl_ff <= hwdata & bnms_pkg::CTRL_RST;
      end
    end
  end

  bnms_fifo #(.WIDTH(bnms_pkg::FRAME_W), .DEPTH(bnms_pkg::FIFO_DEPTH)) u_fifo (
    .clk       (hclk),
    .rst_n     (hresetn),
    .in_valid  (pend_ff),
    .in_ready  (fifo_ready),
    .in_data   (frame_ff),
    .out_valid (fifo_valid),
    .out_ready (fifo_pop),
    .out_data  (fifo_out),
    .count     (fifo_cnt)
  );

  // ************************************************
  // assertions
  // ************************************************
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  AST_MODE_SEL: assert property (init_cnt_ff == 2'h1 && !srst |=> mode_ff == {$past(s2_ff.nv_master), $past(s2_ff.nv_relay)})
    else $error("mode not taken from flags");
  AST_MODE_HOLD: assert property (init_cnt_ff == 2'h0 |=> $stable(mode_ff))
    else $error("mode changed while running");
  AST_FREQ_WIN: assert property (win_cnt_ff != 16'(FREQ_WIN - 1) |=> $stable(freq_16m))
    else $error("frequency moved outside window end");
  AST_LOCK: assert property (locked_ff |=> locked_ff && $stable(freq_16m))
    else $error("locked setting moved");
  AST_LOCK_SRC: assert property ($rose(locked_ff) |-> $past(is_slave ? mc_ok : (mc_ok | sr_ok)))
    else $error("lock without good telegram");
  AST_WDOG: assert property (wd_trip |=> wdog_rst_ff ##1 reset_out)
    else $error("watchdog reset missing");
  AST_HOT: assert property (hot_trip |=> shutdown_ff ##1 (!inductor_en && analog_pd && reset_out))
    else $error("shutdown effects missing");
  AST_LATCH: assert property (shutdown_ff |=> shutdown_ff)
    else $error("shutdown released");
  AST_SHORT: assert property (s2_ff.rail_short && hot_cnt_ff >= 28'(HOT_LIM - 1) |=> shutdown_ff)
    else $error("rail short ignored");
  AST_THRESH: assert property (start |=> thresh_code == 3'($past(s2_ff.adc) >> 1) + 3'($past(s2_ff.adc[0])))
    else $error("threshold not half");
  AST_SLV_STB: assert property (is_slave && rx_strobe_main |-> $past(mc_ok))
    else $error("slave strobe without master call");
  AST_TX: assert property (tx_start |=> tx_busy [*8])
    else $error("encoder did not run");
  AST_SLV_ONLY: assert property (!is_slave |=> !nvm_write_allow && !resp_ready)
    else $error("slave i/o outside slave mode");
  AST_MST_STB: assert property (is_master && rx_strobe_main |-> $past(sr_ok))
    else $error("master strobe without response");
  AST_MON_STB: assert property (is_mon && rx_strobe_aux |-> $past(sr_ok) && !rx_strobe_main)
    else $error("monitor strobes mixed");
  AST_PFAIL: assert property (init_cnt_ff == 2'h0 |=> power_fail_sense_pin_analog == (is_master | is_rep))
    else $error("power-fail pin role wrong");
  AST_ADDR: assert property (is_master |=> tx_line == $past(s2_ff.addr_ch))
    else $error("addressing input not forwarded");
  AST_PULSE: assert property (rx_strobe_main |=> !rx_strobe_main)
    else $error("strobe longer than one cycle");
  COV_MC: cover property (is_slave && rx_strobe_main);
  COV_SR: cover property (is_master && rx_strobe_main);
  COV_MON: cover property (is_mon && rx_strobe_aux);
  COV_FULL: cover property (pend_ff && !fifo_ready);
endmodule : bnms_top

//--- sim/bnms_bus_model.sv
/*
  bus-side node model: sends telegrams as comparator pulses.
  assumes the caller waits for send to return before the next telegram.
*/
`timescale 1ns/1ns
module bnms_bus_model (
  input  wire logic clk,
  output logic      p_pulse,
  output logic      n_pulse
);
  initial begin
    p_pulse = 1'b0;
    n_pulse = 1'b0;
  end
  // one 300-cycle slot; comparators read low when the bus is quiet
  task automatic slot(input logic pol, input logic on);
    if (on) begin
      p_pulse <= ~pol;
      n_pulse <= pol;
    end
    repeat (30) @(posedge clk);
    p_pulse <= 1'b0;
    n_pulse <= 1'b0;
    repeat (270) @(posedge clk);
  endtask : slot
  // mid pulse p for 0, n for 1; equal neighbours need a boundary pulse
  task automatic send(input logic [13:0] b, input int n);
    for (int i = n - 1; i >= 0; i--) begin
      if (i < n - 1) slot(~b[i], b[i] == b[i+1]);
      slot(b[i], 1'b1);
    end
  endtask : send
endmodule : bnms_bus_model

//--- sim/bnms_top_bench.sv
/*
  bench for bnms_top: ahb tasks, telegrams in every mode, supervisor faults.
  assumes bnms_bus_model drives the comparator pulses.
*/
`timescale 1ns/1ns
module bnms_top_bench;
  logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, hready;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
  logic [1:0]  htrans = 2'h0;
  logic        p_pulse, n_pulse, osc = 1'b0, osc_on = 1'b1, hot = 1'b0, shrt = 1'b0, x8 = 1'b1;
  logic        nv_m = 1'b0, nv_r = 1'b0, rv = 1'b0, rdy, smain, saux, txl, f16, ind, apd, rso, pfa, arx, nvw;
  logic [2:0]  adc = 3'h0, thr;
  logic [3:0]  rdat = 4'h0;
  logic        adr = 1'b0, txe, rxl, hrs;
  int          error_cnt = 0, total_checks = 0, cyc = 0, nm = 0, na = 0;
  // **********
  // dut
  // **********
  bnms_top #(.FREQ_WIN(64), .HOT_LIM(32)) bnms_top_inst (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'h2), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hready), .hresp(hrs),
    .p_pulse(p_pulse), .n_pulse(n_pulse), .adc_code(adc), .osc_activity(osc), .over_temp(hot),
    .inductor_output_rail_short(shrt), .xtal_8m(x8), .addressing_channel_input(adr),
    .nv_master_flag(nv_m), .nv_relay_flag(nv_r), .resp_valid(rv), .resp_data(rdat), .resp_ready(rdy),
    .rx_strobe_main(smain), .rx_strobe_aux(saux), .thresh_code(thr), .tx_line(txl), .tx_enable(txe),
    .rx_line(rxl), .freq_16m(f16), .inductor_en(ind), .analog_pd(apd), .reset_out(rso),
    .power_fail_sense_pin_analog(pfa), .addr_rx_enable(arx), .nvm_write_allow(nvw));
  bnms_bus_model bnms_bus_model_inst (.clk(hclk), .p_pulse(p_pulse), .n_pulse(n_pulse));
  always #5 hclk = ~hclk;
  // strobes counted so a two-cycle strobe shows as a surplus
  always @(posedge hclk) begin
    osc <= osc ^ osc_on;
    cyc <= cyc + 1;
    nm <= nm + (smain === 1'b1);
    na <= na + (saux === 1'b1);
    if (cyc == 95000) begin
      error_cnt++;
      end_of_test();
    end
  end
  // **********
  // tasks
  // **********
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic end_of_test();
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : end_of_test
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    do @(posedge hclk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hready !== 1'b1);
    rd = hrdata;
    chk(32'(hrs), 0);
  endtask : ahb
  task automatic boot(input logic [1:0] fl);
    {nv_m, nv_r} <= fl;
    hresetn <= 1'b0;
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (8) @(posedge hclk);
  endtask : boot
  task automatic tel(input logic mc, input logic [10:0] d, input int em, input int ea);
    int bm, ba;
    bm = nm;
    ba = na;
    bnms_bus_model_inst.send(mc ? {1'b0, d, ^d, 1'b1} : {8'h0, d[3:0], ^d[3:0], 1'b1}, mc ? 14 : 7);
    repeat (1400) @(posedge hclk);
    chk(nm - bm, em);
    chk(na - ba, ea);
    chk(32'(rxl), 0);
  endtask : tel
  // **********
  // tests
  // **********
  initial begin
    logic [7:0] md;
    md = {bnms_pkg::BNMS_SLAVE, bnms_pkg::BNMS_MONITOR, bnms_pkg::BNMS_MASTER, bnms_pkg::BNMS_REPEATER};
    for (int i = 0; i < 4; i++) begin
      adc <= 3'(2 * i + 1);
      boot(2'(i));
      chk(32'(f16), 1);
      if (i != 1) chk(32'({txe, pfa, arx, nvw, rdy}), i == 0 ? 7 : 24);
      {nv_m, nv_r} <= ~2'(i);
      if (i >= 2) begin
        adr <= 1'b1;
        repeat (4) @(posedge hclk);
        chk(32'(txl), 1);
        adr <= 1'b0;
      end
      if (i == 0) begin
        rdat <= 4'h5;
        rv <= 1'b1;
        do @(posedge hclk); while (rdy !== 1'b1);
        rv <= 1'b0;
        repeat (152) @(posedge hclk);
        for (int h = 0; h < 14; h++) begin
          chk(32'(txl), 32'(((7'h15 >> (6 - h / 2)) & 7'h1) ^ 7'(h[0] == 1'b0)));
          repeat (300) @(posedge hclk);
        end
      end
      tel(1'b0, 11'h9, i == 2, i % 2);
      ahb(1'b0, bnms_pkg::REG_STATUS, 32'h0);
      chk(32'(rd[4]), i != 0);
      chk(32'(thr), i + 1);
      tel(1'b1, 11'h5a3, i != 2, 0);
      ahb(1'b0, bnms_pkg::REG_STATUS, 32'h0);
      chk(32'({rd[4:3], rd[1:0]}), 32'({2'h2, md[7 - 2 * i -: 2]}));
      x8 <= 1'b0;
      repeat (200) @(posedge hclk);
      chk(32'(f16), 0);
      x8 <= 1'b1;
    end
    // repeater keeps both kinds: slave response first, then master call
    ahb(1'b0, bnms_pkg::REG_RXDATA, 32'h0);
    chk(rd, 32'h0001_c025);
    ahb(1'b0, bnms_pkg::REG_RXDATA, 32'h0);
    chk(rd, 32'h0007_968d);
    bnms_bus_model_inst.slot(1'b0, 1'b1);
    chk(32'(rxl), 1);
    ahb(1'b0, bnms_pkg::REG_CTRL, 32'h0);
    chk(rd, bnms_pkg::CTRL_RST);
    ahb(1'b1, bnms_pkg::REG_CTRL, 32'h0);
    ahb(1'b0, bnms_pkg::REG_CTRL, 32'h0);
    chk(rd, 32'h0);
    ahb(1'b0, 8'h10, 32'h0);
    chk(rd, 32'h0);
    osc_on <= 1'b0;
    repeat (1990) @(posedge hclk);
    chk(32'(rso), 0);
    repeat (30) @(posedge hclk);
    chk(32'(rso), 1);
    osc_on <= 1'b1;
    for (int k = 0; k < 2; k++) begin
      boot(2'h0);
      {hot, shrt} <= k ? 2'h1 : 2'h2;
      repeat (60) @(posedge hclk);
      chk(32'({ind, apd}), 1);
      {hot, shrt} <= 2'h0;
      repeat (60) @(posedge hclk);
      chk(32'({ind, apd}), 1);
    end
    end_of_test();
  end
endmodule : bnms_top_bench
